// ### e1_stream_model.sv
// far side: e1 transmit stream positions and source data
`timescale 1ns/1ps
module e1_stream_model
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // pacing
   input  wire logic       run,
   input  wire logic       slow,
   // stream
   output logic            bitStrobe,
   output logic [4:0]      tsNum,
   output logic [2:0]      bitNum,
   output logic [3:0]      crcFrameNum,
   output logic [3:0]      sigFrameNum,
   output logic            txDataIn
);
   logic [11:0] pos_q;
   logic [1:0]  gap_q;
   logic        go;

   // slow pacing strobes every third cycle
   assign go = run && (!slow || gap_q == 2'h0);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         gap_q <= 2'h0;
      else
         gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
   end

   // positions stand still between strobes; data line toggles there
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pos_q <= 12'h0;
         bitStrobe <= 1'b0;
         {crcFrameNum, tsNum, bitNum} <= 12'h0;
         sigFrameNum <= 4'h5;
         txDataIn <= 1'b0;
      end
      else if (go)
      begin
         pos_q <= pos_q + 12'h1;
         bitStrobe <= 1'b1;
         {crcFrameNum, tsNum, bitNum} <= pos_q;
         sigFrameNum <= pos_q[11:8] + 4'h5;
         txDataIn <= ^pos_q;
      end
      else
      begin
         bitStrobe <= 1'b0;
         txDataIn <= ~txDataIn;
      end
   end
endmodule

// ### e1_tx_boundary_irq_sa_bits.sv
// e1 transmit boundary flags, interrupt output and sa bit insertion
//
// Summary of operation
// - each enable bit lets its boundary flag drive the interrupt pin.
// - the frame flag sets at timeslot 30 bit 7 of every frame.
// - the submultiframe flag sets there in frame 0 of each submultiframe.
// - the crc multiframe flag sets there in frame 0 of each multiframe.
// - the nfas flag sets there in every frame without alignment signal.
// - the signaling flag sets at timeslot 14 bit 1 of signaling frame 0.
// - reading the status register returns the flags and clears them.
// - in t1 mode all four registers of this block are held in reset.
// - a three-bit select picks sa4 to sa8 as the codeword bit position.
// - codeword bits 1..4 go into odd frames 1-7 and 9-15 of timeslot 0.
// - the codeword is latched at the first bit of each submultiframe for that one.
// - with sa8 selected, element 1 comes from bit 0 up to bit 3.
// - each insert enable substitutes its bit, else the bit passes through.
// - insertion works only while the national bit disable is low.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module e1_tx_boundary_irq_sa_bits
#(
   parameter int AW = e1_tx_boundary_pkg::ADDR_W
)
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   // ahb-lite slave
   input  wire logic          hsel,
   input  wire logic [AW-1:0] haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   // transmit stream position and data
   input  wire logic          bitStrobe,
   input  wire logic [4:0]    tsNum,
   input  wire logic [2:0]    bitNum,
   input  wire logic [3:0]    crcFrameNum,
   input  wire logic [3:0]    sigFrameNum,
   input  wire logic          txDataIn,
   output logic               txDataOut,
   output logic               txDataValid,
   // transmitter controls
   input  wire logic          lineStandardSel,
   input  wire logic          intlNatlBitDisable,
   // interrupt
   output logic               irqOut_n
);
   import e1_tx_boundary_pkg::*;

   // ***********************************************
   // reset release
   // ***********************************************
   logic rstnMeta_q;
   logic rstnSync_q;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstnMeta_q <= 1'b0;
         rstnSync_q <= 1'b0;
      end
      else
      begin
         rstnMeta_q <= 1'b1;
         rstnSync_q <= rstnMeta_q;
      end
   end

   // ***********************************************
   // boundary events
   // ***********************************************
   logic                 atBoundary;
   logic                 atSigBoundary;
   logic                 atNatlStart;
   logic [NUM_FLAGS-1:0] flagSet;
   logic                 inT1;

   assign inT1          = !lineStandardSel;
   assign atBoundary    = bitStrobe && (tsNum == TS_BOUNDARY)
                       && (bitNum == BIT_BOUNDARY);
   assign atSigBoundary = bitStrobe && (tsNum == TS_SIG)
                       && (bitNum == BIT_SIG);
   assign atNatlStart   = bitStrobe && (tsNum == TS_NATL)
                       && (bitNum == BIT_FIRST) && (crcFrameNum[2:0] == 3'h0);

   always_comb
   begin
      flagSet            = '0;
      flagSet[FLG_FRAME] = atBoundary;
      flagSet[FLG_SUBMF] = atBoundary && (crcFrameNum[2:0] == 3'h0);
      flagSet[FLG_CRCMF] = atBoundary && (crcFrameNum == 4'h0);
      flagSet[FLG_NFAS]  = atBoundary && crcFrameNum[0];
      flagSet[FLG_SIGMF] = atSigBoundary && (sigFrameNum == 4'h0);
   end

   // ***********************************************
   // bus phases
   // ***********************************************
   logic          busAccept;
   logic          wrPend_q;
   logic [AW-1:0] wrAddr_q;
   logic          wrIrqEn;
   logic          wrNatlSel;
   logic          wrNatlCw;

   // single-word slave with no wait states; hsize is not checked
   assign busAccept = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
      begin
         wrPend_q <= 1'b0;
         wrAddr_q <= '0;
      end
      else
      begin
         wrPend_q <= busAccept && hwrite;
         if (busAccept)
            wrAddr_q <= haddr;
      end
   end

   always_comb
   begin
      wrIrqEn   = 1'b0;
      wrNatlSel = 1'b0;
      wrNatlCw  = 1'b0;
      // in t1 mode a write neither lands nor forwards to a read behind it
      if (!(wrPend_q && hready) || inT1)
         wrIrqEn = 1'b0;
      else if (wrAddr_q == ADDR_IRQ_EN)
         wrIrqEn = 1'b1;
      else if (wrAddr_q == ADDR_NATL_SEL)
         wrNatlSel = 1'b1;
      else if (wrAddr_q == ADDR_NATL_CW)
         wrNatlCw = 1'b1;
   end

   // ***********************************************
   // registers
   // ***********************************************
   logic [NUM_FLAGS-1:0] irqEn_q;
   logic [NUM_FLAGS-1:0] status_q;
   logic [2:0]           natlSel_q;
   logic [7:0]           natlCw_q;
   logic                 rdStatus;

   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
         irqEn_q <= RST_IRQ_EN;
      else if (inT1)
         irqEn_q <= RST_IRQ_EN;
      else if (wrIrqEn)
         irqEn_q <= hwdata[NUM_FLAGS-1:0];
   end

   // a new event in the read cycle wins over the clear
   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
         status_q <= RST_STATUS;
      else if (inT1)
         status_q <= RST_STATUS;
      else if (rdStatus)
         status_q <= flagSet;
      else
         status_q <= status_q | flagSet;
   end

   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
      begin
         natlSel_q <= RST_NATL_SEL;
         natlCw_q  <= RST_NATL_CW;
      end
      else if (inT1)
      begin
         natlSel_q <= RST_NATL_SEL;
         natlCw_q  <= RST_NATL_CW;
      end
      else
      begin
         if (wrNatlSel)
            natlSel_q <= hwdata[SEL_LSB +: SEL_W];
         if (wrNatlCw)
            natlCw_q <= hwdata[7:0];
      end
   end

   // ***********************************************
   // read path
   // ***********************************************
   logic [NUM_FLAGS-1:0] irqEnNow;
   logic [2:0]           natlSelNow;
   logic [7:0]           natlCwNow;
   logic [31:0]          rdValue;
   logic [31:0]          hrdata_q;

   // forward a write in its data phase to a read right behind it
   assign irqEnNow   = wrIrqEn ? hwdata[NUM_FLAGS-1:0] : irqEn_q;
   assign natlSelNow = wrNatlSel ? hwdata[SEL_LSB +: SEL_W] : natlSel_q;
   assign natlCwNow  = wrNatlCw ? hwdata[7:0] : natlCw_q;

   always_comb
   begin
      rdValue  = 32'h0000_0000;
      rdStatus = 1'b0;
      if (!(busAccept && !hwrite))
         rdValue = 32'h0000_0000;
      else if (haddr == ADDR_IRQ_EN)
         rdValue = {{(32-NUM_FLAGS){1'b0}}, irqEnNow};
      else if (haddr == ADDR_STATUS)
      begin
         rdValue  = {{(32-NUM_FLAGS){1'b0}}, status_q};
         rdStatus = !inT1;
      end
      else if (haddr == ADDR_NATL_SEL)
         rdValue = {24'h00_0000, natlSelNow, 5'h00};
      else if (haddr == ADDR_NATL_CW)
         rdValue = {24'h00_0000, natlCwNow};
   end

   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
         hrdata_q <= 32'h0000_0000;
      else
         hrdata_q <= rdValue;
   end

   assign hrdata = hrdata_q;

   // ***********************************************
   // codeword latch and insertion
   // ***********************************************
   logic [7:0] cwLatch_q;
   logic [2:0] selLatch_q;
   logic       txDataOut_q;
   logic       txDataValid_q;
   sa_ins_if   saBus ();

   // latching at the first bit of a submultiframe means a write never
   // tears a codeword across its four frames
   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
      begin
         cwLatch_q  <= RST_NATL_CW;
         selLatch_q <= RST_NATL_SEL;
      end
      else if (inT1)
      begin
         cwLatch_q  <= RST_NATL_CW;
         selLatch_q <= RST_NATL_SEL;
      end
      else if (atNatlStart)
      begin
         cwLatch_q  <= natlCw_q;
         selLatch_q <= natlSel_q;
      end
   end

   assign saBus.tsNum       = tsNum;
   assign saBus.bitNum      = bitNum;
   assign saBus.crcFrameNum = crcFrameNum;
   assign saBus.dataIn      = txDataIn;
   assign saBus.codeword    = cwLatch_q;
   assign saBus.sel         = selLatch_q;
   assign saBus.natlDisable = intlNatlBitDisable;

   sa_bit_inserter u_inserter
   (
      .bus (saBus.ins)
   );

   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
      begin
         txDataOut_q   <= 1'b0;
         txDataValid_q <= 1'b0;
      end
      else
      begin
         txDataValid_q <= bitStrobe;
         if (bitStrobe)
            txDataOut_q <= saBus.dataOut;
      end
   end

   assign txDataOut   = txDataOut_q;
   assign txDataValid = txDataValid_q;

   // ***********************************************
   // interrupt output
   // ***********************************************
   logic irqOutN_q;

   always_ff @(posedge ref_clk or negedge rstnSync_q)
   begin
      if (!rstnSync_q)
         irqOutN_q <= 1'b1;
      else
         irqOutN_q <= !(|(status_q & irqEn_q));
   end

   assign irqOut_n = irqOutN_q;

   // ***********************************************
   // assertions
   // ***********************************************
   logic expInsert;
   logic expBit;

   assign expInsert = (tsNum == TS_NATL) && crcFrameNum[0]
                   && saValid(selLatch_q) && !intlNatlBitDisable
                   && (bitNum == saBitIdx(selLatch_q))
                   && saEnable(cwLatch_q, crcFrameNum[2:1]);
   assign expBit    = saElement(cwLatch_q, selLatch_q, crcFrameNum[2:1]);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstnSync_q);

   frame_flag_a: assert property (
      atBoundary && lineStandardSel |=> status_q[FLG_FRAME])
      else $error("frame flag not set at boundary");
   submf_flag_a: assert property (
      atBoundary && lineStandardSel && (crcFrameNum[2:0] == 3'h0)
      |=> status_q[FLG_SUBMF])
      else $error("submultiframe flag not set");
   crcmf_flag_a: assert property (
      atBoundary && lineStandardSel && (crcFrameNum == 4'h0)
      |=> status_q[FLG_CRCMF] && status_q[FLG_SUBMF])
      else $error("crc multiframe flag not set");
   nfas_flag_a: assert property (
      !status_q[FLG_NFAS] && !(atBoundary && crcFrameNum[0])
      |=> !status_q[FLG_NFAS])
      else $error("nfas flag set outside an nfas boundary");
   sig_flag_a: assert property (
      atSigBoundary && lineStandardSel && (sigFrameNum == 4'h0)
      |=> status_q[FLG_SIGMF])
      else $error("signaling multiframe flag not set");
   irq_gate_a: assert property (
      |(status_q & irqEn_q) |=> !irqOut_n)
      else $error("enabled flag did not pull interrupt low");
   irq_mask_a: assert property (
      !(|(status_q & irqEn_q)) |=> irqOut_n)
      else $error("interrupt low with no enabled flag");
   read_clear_a: assert property (
      rdStatus && !(|flagSet)
      |=> (status_q == '0) && (hrdata[NUM_FLAGS-1:0] == $past(status_q)))
      else $error("status read did not return and clear flags");
   t1_hold_a: assert property (
      inT1 |=> (irqEn_q == RST_IRQ_EN) && (status_q == RST_STATUS)
               && (natlSel_q == RST_NATL_SEL) && (natlCw_q == RST_NATL_CW))
      else $error("registers not held in t1 mode");
   latch_load_a: assert property (
      atNatlStart && lineStandardSel |=> cwLatch_q == $past(natlCw_q))
      else $error("codeword not latched at submultiframe start");
   latch_hold_a: assert property (
      !atNatlStart && lineStandardSel |=> $stable(cwLatch_q))
      else $error("codeword latch changed mid submultiframe");
   sa_insert_a: assert property (
      bitStrobe && expInsert |=> txDataValid && (txDataOut == $past(expBit)))
      else $error("codeword bit not inserted");
   pass_through_a: assert property (
      bitStrobe && !expInsert |=> txDataOut == $past(txDataIn))
      else $error("stream bit altered outside insertion");
   natl_disable_a: assert property (
      bitStrobe && intlNatlBitDisable |=> txDataOut == $past(txDataIn))
      else $error("insertion while national bits disabled");

   frame_event_c: cover property (atBoundary ##1 !irqOut_n);
   sig_event_c:   cover property (flagSet[FLG_SIGMF] ##[1:4] rdStatus);
   insert_c:      cover property (bitStrobe && expInsert
                                  && (selLatch_q == SEL_SA8));
   read_clear_c:  cover property (rdStatus && (|status_q));
endmodule

// ### e1_tx_boundary_pkg.sv
// constants and helpers shared by the e1 transmit boundary block
package e1_tx_boundary_pkg;

   // ***********************************************
   // register map (index, byte address = 4 * index)
   // ***********************************************
   localparam int         ADDR_W        = 12;
   localparam logic [7:0] IDX_IRQ_EN    = 8'h84;
   localparam logic [7:0] IDX_STATUS    = 8'h85;
   localparam logic [7:0] IDX_NATL_SEL  = 8'h86;
   localparam logic [7:0] IDX_NATL_CW   = 8'h87;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = {2'h0, IDX_IRQ_EN, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_NATL_SEL = {2'h0, IDX_NATL_SEL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_NATL_CW  = {2'h0, IDX_NATL_CW, 2'h0};

   // ***********************************************
   // field positions and reset values
   // ***********************************************
   localparam int         NUM_FLAGS     = 5;
   localparam int         FLG_FRAME     = 0;
   localparam int         FLG_SUBMF     = 1;
   localparam int         FLG_CRCMF     = 2;
   localparam int         FLG_NFAS      = 3;
   localparam int         FLG_SIGMF     = 4;
   localparam int         SEL_LSB       = 5;
   localparam int         SEL_W         = 3;
   localparam int         CW_EN_LSB     = 4;
   localparam int         CW_BITS_LSB   = 0;
   localparam logic [4:0] RST_IRQ_EN    = 5'h00;
   localparam logic [4:0] RST_STATUS    = 5'h00;
   localparam logic [2:0] RST_NATL_SEL  = 3'h0;
   localparam logic [7:0] RST_NATL_CW   = 8'h0f;

   // ***********************************************
   // stream positions (bit number n is coded n-1)
   // ***********************************************
   localparam logic [4:0] TS_BOUNDARY   = 5'h1e;
   localparam logic [2:0] BIT_BOUNDARY  = 3'h6;
   localparam logic [4:0] TS_SIG        = 5'h0e;
   localparam logic [2:0] BIT_SIG       = 3'h0;
   localparam logic [4:0] TS_NATL       = 5'h00;
   localparam logic [2:0] BIT_FIRST     = 3'h0;

   typedef enum logic [2:0]
   {
      SEL_SA4 = 3'h3,
      SEL_SA5 = 3'h4,
      SEL_SA6 = 3'h5,
      SEL_SA7 = 3'h6,
      SEL_SA8 = 3'h7
   } natl_sel_e;

   // select codes below sa4 insert nothing
   function automatic logic saValid(input logic [2:0] sel);
      return sel >= SEL_SA4;
   endfunction

   // sa4..sa8 sit in bits 4..8, coded 3..7: same as the select code
   function automatic logic [2:0] saBitIdx(input logic [2:0] sel);
      return sel;
   endfunction

   function automatic logic saEnable(input logic [7:0] cw,
                                     input logic [1:0] elem);
      logic [3:0] byElem;
      byElem = {cw[CW_EN_LSB], cw[CW_EN_LSB+1], cw[CW_EN_LSB+2],
                cw[CW_EN_LSB+3]};
      return byElem[elem];
   endfunction

   function automatic logic saElement(input logic [7:0] cw,
                                      input logic [2:0] sel,
                                      input logic [1:0] elem);
      logic [3:0] byElem;
      byElem = {cw[CW_BITS_LSB], cw[CW_BITS_LSB+1], cw[CW_BITS_LSB+2],
                cw[CW_BITS_LSB+3]};
      if (sel == SEL_SA8)
         byElem = cw[CW_BITS_LSB +: 4];
      return byElem[elem];
   endfunction

endpackage

// ### sa_bit_inserter.sv
// national bit codeword substitution into timeslot 0
`timescale 1ns/1ps
module sa_bit_inserter
(
   // stream and latched codeword
   sa_ins_if.ins bus
);
   import e1_tx_boundary_pkg::*;

   // ***********************************************
   // slot match and substitution
   // ***********************************************
   logic [1:0] element;
   logic       inNatlSlot;
   logic       doInsert;

   // frames 1,3,5,7 and 9,11,13,15 carry elements 1..4
   assign element    = bus.crcFrameNum[2:1];
   assign inNatlSlot = (bus.tsNum == TS_NATL) && bus.crcFrameNum[0]
                    && saValid(bus.sel)
                    && (bus.bitNum == saBitIdx(bus.sel));
   assign doInsert   = inNatlSlot && !bus.natlDisable
                    && saEnable(bus.codeword, element);
   // sa8 takes the codeword bits in reverse order
   assign bus.dataOut = doInsert
                      ? saElement(bus.codeword, bus.sel, element)
                      : bus.dataIn;
endmodule

// ### sa_ins_if.sv
// carrier between the register side and the national bit inserter
`timescale 1ns/1ps
interface sa_ins_if;
   logic [4:0] tsNum;
   logic [2:0] bitNum;
   logic [3:0] crcFrameNum;
   logic       dataIn;
   logic [7:0] codeword;
   logic [2:0] sel;
   logic       natlDisable;
   logic       dataOut;

   modport ctrl
   (
      output tsNum, bitNum, crcFrameNum, dataIn, codeword, sel, natlDisable,
      input  dataOut
   );
   modport ins
   (
      input  tsNum, bitNum, crcFrameNum, dataIn, codeword, sel, natlDisable,
      output dataOut
   );
endinterface

// ### test_e1_tx_boundary_irq_sa_bits.sv
// self-checking bench for the e1 transmit boundary block
`timescale 1ns/1ps
module test_e1_tx_boundary_irq_sa_bits;
   import e1_tx_boundary_pkg::*;

   // ************************
   // signals
   // ************************
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hready, hreadyout, hresp, txDataOut, txDataValid;
   logic [31:0] hrdata;
   logic        bitStrobe, txDataIn, irqOut_n;
   logic [4:0]  tsNum;
   logic [2:0]  bitNum;
   logic [3:0]  crcFrameNum, sigFrameNum;
   logic        lineStandardSel = 1'b1;
   logic        intlNatlBitDisable = 1'b0;
   logic        run = 1'b0;
   logic        slow = 1'b0;
   logic        live = 1'b0;
   logic        expQ = 1'b0;
   logic        prevStb = 1'b0;
   logic [2:0]  pendSel = 3'h0;
   logic [2:0]  actSel = 3'h0;
   logic [7:0]  pendCw = 8'h0f;
   logic [7:0]  actCw = 8'h0f;
   logic [1:0]  el;
   int          err_count = 0;
   int          n_checks = 0;
   logic [2:0]  selTab [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7,
                               3'h4};
   logic [7:0]  cwTab [8] = '{8'hf6, 8'hb6, 8'hb9, 8'h7c, 8'hd3, 8'hb6,
                              8'hf1, 8'hf0};

   assign hready = hreadyout;
   always #25 ref_clk = ~ref_clk;

   e1_tx_boundary_irq_sa_bits dut_u (.ref_clk(ref_clk), .rstn(rstn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .bitStrobe(bitStrobe), .tsNum(tsNum), .bitNum(bitNum),
      .crcFrameNum(crcFrameNum), .sigFrameNum(sigFrameNum),
      .txDataIn(txDataIn), .txDataOut(txDataOut),
      .txDataValid(txDataValid), .lineStandardSel(lineStandardSel),
      .intlNatlBitDisable(intlNatlBitDisable), .irqOut_n(irqOut_n));

   e1_stream_model model_u (.ref_clk(ref_clk), .rstn(rstn), .run(run),
      .slow(slow), .bitStrobe(bitStrobe), .tsNum(tsNum), .bitNum(bitNum),
      .crcFrameNum(crcFrameNum), .sigFrameNum(sigFrameNum),
      .txDataIn(txDataIn));

   // ************************
   // tasks
   // ************************
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   // single ahb transfer; read data taken at the data phase edge
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? wd : 32'h0;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      xfer(1'b1, a, d, rd);
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
      logic [31:0] rd;
      xfer(1'b0, a, 32'h0, rd);
      check(nm, e, rd);
   endtask

   task automatic cfg(input logic [2:0] s, input logic [7:0] c);
      wr(ADDR_NATL_SEL, {24'h0, s, 5'h0});
      wr(ADDR_NATL_CW, {24'h0, c});
      pendSel = s;
      pendCw = c;
   endtask

   task automatic wait_pos(input logic [3:0] f, input logic [4:0] t);
      do
         @(posedge ref_clk);
      while (!(bitStrobe === 1'b1 && crcFrameNum == f && tsNum == t
               && bitNum == 3'h0));
   endtask

   // clear flags at ts0 of frame f, read what set up to ts1
   task automatic flag_chk(input logic [3:0] f, input logic [4:0] t0,
                           input logic [4:0] t1, input logic [4:0] e);
      logic [31:0] rd;
      wait_pos(f, t0);
      xfer(1'b0, ADDR_STATUS, 32'h0, rd);
      wait_pos(f, t1);
      rdchk("status", ADDR_STATUS, {27'h0, e});
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ************************
   // stream scoreboard
   // ************************
   always @(posedge ref_clk)
   begin
      if (live)
      begin
         check("txDataValid", {31'h0, prevStb}, {31'h0, txDataValid});
         if (txDataValid === 1'b1)
            check("txDataOut", {31'h0, expQ}, {31'h0, txDataOut});
      end
      prevStb = bitStrobe;
      if (bitStrobe === 1'b1)
      begin
         if (tsNum == 5'h0 && bitNum == 3'h0 && crcFrameNum[2:0] == 3'h0)
         begin
            actSel = pendSel;
            actCw = pendCw;
         end
         el = crcFrameNum[2:1];
         expQ = txDataIn;
         if (!intlNatlBitDisable && actSel >= 3'h3 && tsNum == 5'h0 &&
             bitNum == actSel && crcFrameNum[0] && actCw[7 - el])
            expQ = (actSel == 3'h7) ? actCw[el] : actCw[3 - el];
      end
   end

   initial
   begin
      repeat (80000) @(posedge ref_clk);
      err_count++;
      wrap_up();
   end

   // ************************
   // tests
   // ************************
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      live <= 1'b1;
      rdchk("irq_enable", ADDR_IRQ_EN, 32'h0);
      rdchk("status", ADDR_STATUS, 32'h0);
      rdchk("select", ADDR_NATL_SEL, 32'h0);
      rdchk("codeword", ADDR_NATL_CW, 32'h0f);
      wr(12'h220, 32'hffff_ffff);
      rdchk("unmapped", 12'h220, 32'h0);
      wr(ADDR_IRQ_EN, 32'hffff_ffff);
      rdchk("irq_enable", ADDR_IRQ_EN, 32'h1f);
      wr(ADDR_NATL_SEL, 32'hffff_ffff);
      rdchk("select", ADDR_NATL_SEL, 32'he0);
      wr(ADDR_NATL_CW, 32'h1a5);
      rdchk("codeword", ADDR_NATL_CW, 32'ha5);
      wr(ADDR_IRQ_EN, 32'h0);
      cfg(3'h0, 8'h0f);
      run <= 1'b1;
      flag_chk(4'h0, 5'h14, 5'h1f, 5'h07);
      flag_chk(4'h1, 5'h14, 5'h1f, 5'h09);
      flag_chk(4'h8, 5'h14, 5'h1f, 5'h03);
      flag_chk(4'hb, 5'h0a, 5'h14, 5'h10);
      flag_chk(4'hc, 5'h0a, 5'h14, 5'h00);
      wait_pos(4'hb, 5'h14);
      run <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("irqOut_n", 32'h1, {31'h0, irqOut_n});
      // all five flags stand now; each enable alone must reach the pin
      for (int i = 0; i < 5; i++)
      begin
         wr(ADDR_IRQ_EN, 32'h1 << i);
         repeat (3) @(posedge ref_clk);
         check("irqOut_n", 32'h0, {31'h0, irqOut_n});
      end
      rdchk("status", ADDR_STATUS, 32'h1f);
      rdchk("status", ADDR_STATUS, 32'h0);
      repeat (3) @(posedge ref_clk);
      check("irqOut_n", 32'h1, {31'h0, irqOut_n});
      run <= 1'b1;
      // writes mid submultiframe; the scoreboard tracks the latch points
      for (int k = 0; k < 8; k++)
      begin
         wait_pos(k[0] ? 4'hb : 4'h3, 5'h14);
         cfg(selTab[k], cwTab[k]);
         intlNatlBitDisable <= (k == 7);
         slow <= (k == 1);
      end
      wait_pos(4'h3, 5'h14);
      wait_pos(4'hb, 5'h14);
      run <= 1'b0;
      intlNatlBitDisable <= 1'b0;
      lineStandardSel <= 1'b0;
      repeat (2) @(posedge ref_clk);
      wr(ADDR_NATL_CW, 32'h55);
      rdchk("codeword", ADDR_NATL_CW, 32'h0f);
      rdchk("select", ADDR_NATL_SEL, 32'h0);
      rdchk("irq_enable", ADDR_IRQ_EN, 32'h0);
      rdchk("status", ADDR_STATUS, 32'h0);
      wrap_up();
   end
endmodule
